// ===== hdl/acs_defines.svh
// Constants for the converter control block: fields, reset values, timing counts
// ============================================================================
// Overview of operation
// - Serial clock held low longer than the timeout resets the serial interface logic.
// - The host keeps the input bit stable around the falling edge, where it is sampled.
// - A new output bit is shifted out after each rising serial clock edge except the first of a frame.
// - The output line is driven only while chip select is low and released after it rises.
// - Single-shot mode performs one conversion per request and stores it as the result.
// - After a single-shot conversion the converter powers down until the next request.
// - Continuous mode starts the next conversion as soon as one completes.
// - Continuous conversions complete at the programmed data rate.
// - A read returns the result captured at the last serial interface reset or frame end, never a partial one.
// - The filter decimates the modulator bitstream into proportional codes, one per period.
// - The modulator clock is the internal oscillator divided by four.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ============================================================================
// Configuration word fields
`define ACS_CFG_START_BIT 15
`define ACS_CFG_MODE_BIT  8
`define ACS_CFG_DR_MSB    7
`define ACS_CFG_DR_LSB    5
`define ACS_CFG_RST       16'h0180

// ============================================================================
// Clocking and timing
`define ACS_CLK_HZ        100000000
`define ACS_CLK_PERIOD_NS 10
`define ACS_OSC_HZ        1000000
`define ACS_OSC_DIV       (`ACS_CLK_HZ / `ACS_OSC_HZ)
`define ACS_MOD_DIV       4
`define ACS_SCLK_TO_US    30800
`define ACS_SCLK_TO_CYC   ((`ACS_SCLK_TO_US * 1000) / `ACS_CLK_PERIOD_NS)

// ============================================================================
// Frame and result format
`define ACS_FRAME_BITS    16
`define ACS_CODE_MAX      16'h7FFF
`define ACS_CODE_MIN      16'h8000
`define ACS_FIFO_DEPTH    8

`endif

// ===== hdl/acs_pkg.sv
// Types shared by the converter control block
package acs_pkg;

	typedef enum logic {
		ACS_ST_PDOWN,
		ACS_ST_CONV
	} acs_state_t;

	typedef struct packed {
		logic              sclk;
		logic [3:0]        bit_cnt;
		logic [15:0]       rx;
		logic [15:0]       tx;
		logic [31:0]       to_cnt;
		logic              pend_v;
		logic [15:0]       pend;
		logic [15:0]       cfg;
		acs_state_t        st;
		logic [6:0]        osc_div;
		logic [1:0]        mod_div;
		logic              mod_tick;
		logic [15:0]       smp_cnt;
		logic signed [16:0] acc;
		logic [15:0]       result;
		logic              result_new;
		logic              dout;
		logic              oe;
		logic              busy;
	} acs_regs_t;

endpackage

// ===== hdl/acs_stream_if.sv
// Valid/ready word stream between the serial front end and the word buffer
`timescale 1ns/1ps
interface acs_stream_if #(
	parameter int W = 16
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== hdl/acs_fifo.sv
// Parameterised word buffer with valid/ready on both sides
`timescale 1ns/1ps
module acs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  logic clk_sys_i,
	input  logic rst_i,
	// Streams
	acs_stream_if.snk wr,
	acs_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
	} acs_fifo_regs_t;

	acs_fifo_regs_t q;
	acs_fifo_regs_t d;
	logic           do_wr;
	logic           do_rd;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign wr.ready = (q.count != (AW + 1)'(DEPTH));
	assign rd.valid = (q.count != '0);
	assign rd.data  = q.mem[q.rptr];
	assign do_wr    = wr.valid & wr.ready;
	assign do_rd    = rd.valid & rd.ready;

	always_comb begin
		d = q;
		if (do_wr) begin
			d.mem[q.wptr] = wr.data;
			d.wptr        = bump(q.wptr);
		end
		if (do_rd) begin
			d.rptr = bump(q.rptr);
		end
		case ({do_wr, do_rd})
			2'b10:   d.count = q.count + (AW + 1)'(1);
			2'b01:   d.count = q.count - (AW + 1)'(1);
			default: d.count = q.count;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// ===== hdl/acs_top.sv
// Converter sequencing, decimation filter and serial interface
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_top
	import acs_pkg::*;
#(
	parameter int TIMEOUT_CYC = `ACS_SCLK_TO_CYC,
	parameter int FIFO_DEPTH  = `ACS_FIFO_DEPTH,
	// System clocks per oscillator period; at most 128 fits the divider
	parameter int OSC_DIV     = `ACS_OSC_DIV
) (
	// Clock and reset
	input  logic clk_sys_i,
	input  logic rst_i,
	// Serial link
	input  logic cs_n_i,
	input  logic sclk_i,
	input  logic din_i,
	output logic dout_o,
	output logic dout_oe_o,
	// Modulator
	input  logic mod_bit_i,
	output logic mod_sample_o,
	// Status
	output logic conv_busy_o,
	output logic result_new_o
);

	// ========================================================================
	// Helpers

	// Oversampling ratio for each data rate code (modulator rate / data rate)
	function automatic logic [15:0] osr(input logic [2:0] dr);
		case (dr)
			3'd0:    osr = 16'd31250;
			3'd1:    osr = 16'd15625;
			3'd2:    osr = 16'd7812;
			3'd3:    osr = 16'd3906;
			3'd4:    osr = 16'd1953;
			3'd5:    osr = 16'd1000;
			3'd6:    osr = 16'd526;
			default: osr = 16'd290;
		endcase
	endfunction

	// Gain of 2^31 / ratio, so full-scale density maps to full-scale code
	function automatic logic [23:0] gain(input logic [2:0] dr);
		case (dr)
			3'd0:    gain = 24'd68719;
			3'd1:    gain = 24'd137439;
			3'd2:    gain = 24'd274895;
			3'd3:    gain = 24'd549791;
			3'd4:    gain = 24'd1099582;
			3'd5:    gain = 24'd2147484;
			3'd6:    gain = 24'd4082668;
			default: gain = 24'd7405084;
		endcase
	endfunction

	// Scale the signed count to a 16-bit code with saturation
	function automatic logic [15:0] scale(input logic signed [16:0] acc,
	                                      input logic [2:0] dr);
		logic signed [41:0] p;
		p = $signed({{25{acc[16]}}, acc}) * $signed({18'd0, gain(dr)});
		if (p[41] && !(&p[40:31])) begin
			scale = `ACS_CODE_MIN;
		end else if (!p[41] && (|p[40:31])) begin
			scale = `ACS_CODE_MAX;
		end else begin
			scale = p[31:16];
		end
	endfunction

	// ========================================================================
	// Word buffer for configuration words received over the link

	acs_stream_if #(.W(16)) wr_if ();
	acs_stream_if #(.W(16)) rd_if ();

	acs_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr        (wr_if),
		.rd        (rd_if)
	);

	// ========================================================================
	// State

	acs_regs_t q;
	acs_regs_t d;
	logic      sclk_rise;
	logic      sclk_fall;
	logic      to_hit;
	logic      spi_rst;
	logic      osc_tick;
	logic      pop;
	logic      pend_keep;
	logic      done;
	logic [2:0] dr;
	logic [15:0] nc;
	logic signed [16:0] acc_n;

	assign wr_if.valid = q.pend_v;
	assign wr_if.data  = q.pend;
	assign rd_if.ready = pop;

	assign sclk_rise = sclk_i & ~q.sclk;
	assign sclk_fall = ~sclk_i & q.sclk;
	assign to_hit    = (q.to_cnt == 32'(TIMEOUT_CYC));
	assign spi_rst   = cs_n_i | to_hit;

	always_comb begin
		d         = q;
		pop       = 1'b0;
		done      = 1'b0;
		nc        = q.cfg;
		acc_n     = q.acc;
		dr        = q.cfg[`ACS_CFG_DR_MSB:`ACS_CFG_DR_LSB];
		d.sclk    = sclk_i;
		d.result_new = 1'b0;

		// ====================================================================
		// Serial clock low timeout
		if (sclk_i) begin
			d.to_cnt = '0;
		end else if (!to_hit) begin
			d.to_cnt = q.to_cnt + 32'd1;
		end

		// ====================================================================
		// Serial shifter
		// A word that finds the buffer full waits here; later frames are ignored
		pend_keep = q.pend_v & ~wr_if.ready;
		d.pend_v  = pend_keep;
		if (spi_rst) begin
			d.bit_cnt = '0;
			d.rx      = '0;
			d.tx      = q.result;
		end else begin
			if (sclk_fall) begin
				d.rx      = {q.rx[14:0], din_i};
				d.bit_cnt = q.bit_cnt + 4'd1;
				if (q.bit_cnt == 4'(`ACS_FRAME_BITS - 1)) begin
					// Counting alone ends the frame when select never rises
					d.bit_cnt = '0;
					d.tx      = q.result;
					if (!pend_keep) begin
						d.pend_v = 1'b1;
						d.pend   = {q.rx[14:0], din_i};
					end
				end
			end
			// First rising edge keeps the MSB that was loaded at frame start
			if (sclk_rise && q.bit_cnt != '0) begin
				d.tx = {q.tx[14:0], 1'b0};
			end
		end
		d.dout = d.tx[15];
		d.oe   = ~cs_n_i;

		// ====================================================================
		// Oscillator and modulator clock
		osc_tick = (q.osc_div == 7'(OSC_DIV - 1));
		d.osc_div = osc_tick ? '0 : q.osc_div + 7'd1;
		if (osc_tick) begin
			d.mod_div = q.mod_div + 2'd1;
		end
		d.mod_tick = osc_tick & (q.mod_div == 2'(`ACS_MOD_DIV - 1));

		// ====================================================================
		// Conversion sequencer
		case (q.st)
			ACS_ST_PDOWN: begin
				d.busy = 1'b0;
				if (rd_if.valid) begin
					pop   = 1'b1;
					d.cfg = rd_if.data;
					if (rd_if.data[`ACS_CFG_START_BIT] ||
					    !rd_if.data[`ACS_CFG_MODE_BIT]) begin
						d.st      = ACS_ST_CONV;
						d.busy    = 1'b1;
						d.acc     = '0;
						d.smp_cnt = '0;
					end
				end
			end
			ACS_ST_CONV: begin
				if (q.mod_tick) begin
					acc_n = mod_bit_i ? q.acc + 17'sd1 : q.acc - 17'sd1;
					d.acc = acc_n;
					if (q.smp_cnt == osr(dr) - 16'd1) begin
						done = 1'b1;
					end else begin
						d.smp_cnt = q.smp_cnt + 16'd1;
					end
				end
				if (done) begin
					// Only whole conversions reach the result register
					d.result     = scale(acc_n, dr);
					d.result_new = 1'b1;
					d.acc        = '0;
					d.smp_cnt    = '0;
					// New settings take effect only between conversions
					if (rd_if.valid) begin
						pop = 1'b1;
						nc  = rd_if.data;
					end
					d.cfg = nc;
					if (!nc[`ACS_CFG_MODE_BIT]) begin
						d.st = ACS_ST_CONV;
					end else if (pop && nc[`ACS_CFG_START_BIT]) begin
						d.st = ACS_ST_CONV;
					end else begin
						d.st   = ACS_ST_PDOWN;
						d.busy = 1'b0;
					end
				end
			end
			default: begin
				d.st   = ACS_ST_PDOWN;
				d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q     <= '0;
			q.cfg <= `ACS_CFG_RST;
			q.st  <= ACS_ST_PDOWN;
		end else begin
			q <= d;
		end
	end

	// ========================================================================
	// Outputs, all from flops
	assign dout_o       = q.dout;
	assign dout_oe_o    = q.oe;
	assign mod_sample_o = q.mod_tick;
	assign conv_busy_o  = q.busy;
	assign result_new_o = q.result_new;

endmodule

// ===== testbench/acs_top_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_top_chk #(
	parameter int MOD_GAP = 400
) (
	// Clock and reset
	input logic clk_sys_i,
	input logic rst_i,
	// Serial link
	input logic cs_n_i,
	input logic sclk_i,
	input logic din_i,
	input logic dout_o,
	input logic dout_oe_o,
	// Converter
	input logic mod_bit_i,
	input logic mod_sample_o,
	input logic conv_busy_o,
	input logic result_new_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ========
	// Cycles since the last modulator sample
	logic [9:0] gap_q;
	logic       seen_q;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			gap_q  <= 10'h000;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= mod_sample_o ? 10'h001 : gap_q + 10'h001;
			seen_q <= seen_q | mod_sample_o;
		end
	end
	// ========
	// Assertions
	mod_period_a: assert property (seen_q |-> mod_sample_o == (gap_q == 10'(MOD_GAP)))
		else $error("modulator sample spacing wrong");
	oe_on_a: assert property (!cs_n_i ##1 !cs_n_i |-> dout_oe_o)
		else $error("output not driven while selected");
	oe_off_a: assert property ($rose(cs_n_i) |=> !dout_oe_o)
		else $error("output still driven after deselect");
	hold_high_a: assert property (sclk_i && $past(sclk_i) && $past(sclk_i, 2) |-> $stable(dout_o))
		else $error("output bit moved while clock high");
	new_pulse_a: assert property (result_new_o |=> !result_new_o)
		else $error("result flag longer than one cycle");
	new_busy_a: assert property (result_new_o |-> $past(conv_busy_o))
		else $error("result without conversion");
	busy_len_a: assert property ($rose(conv_busy_o) |=> conv_busy_o [*8])
		else $error("conversion ended too soon");
	rst_quiet_a: assert property ($fell(rst_i) |-> !conv_busy_o && !dout_oe_o && !result_new_o)
		else $error("outputs active after reset");
	cover property ($rose(conv_busy_o));
	cover property (result_new_o);
	cover property ($fell(dout_oe_o));
endmodule

bind acs_top acs_top_chk #(.MOD_GAP(OSC_DIV * `ACS_MOD_DIV)) acs_top_chk_i (.clk_sys_i, .rst_i,
	.cs_n_i, .sclk_i, .din_i, .dout_o,
	.dout_oe_o, .mod_bit_i, .mod_sample_o, .conv_busy_o, .result_new_o);

// ===== testbench/acs_host_model.sv
// Serial host model on the far side of the converter link
`timescale 1ns/1ps
module acs_host_model (
	// Clock
	input  logic clk_sys_i,
	// Link
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o,
	input  logic dout_i,
	input  logic dout_oe_i
);
	logic last_q = 1'b0;
	// Released line shows the inverse of the last driven bit
	wire  line = dout_oe_i ? dout_i : ~last_q;
	always @(posedge clk_sys_i) if (dout_oe_i) last_q <= dout_i;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o  = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// Frame of n bits, MSB first; stay keeps chip select low afterwards
	task automatic xfer(input logic [15:0] w, input int n, input logic stay,
		output logic [15:0] r);
		r = 16'h0000;
		cs_n_o = 1'b0;
		wait_n(3);
		for (int k = 15; k > 15 - n; k--) begin
			sclk_o = 1'b1;
			din_o  = w[k];
			wait_n(5);
			sclk_o = 1'b0;
			r[k]   = line;
			wait_n(5);
		end
		din_o = ~din_o;
		if (!stay) cs_n_o = 1'b1;
		wait_n(3);
	endtask
endmodule

// ===== testbench/test_acs_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module test_acs_top;
	localparam int TO_CYC = 50;
	localparam int OSR7   = 290;
	// Fast oscillator keeps a 290-sample conversion near 11600 cycles
	localparam int OSC_DIV = 10;
	localparam int MOD_DIV = 4;
	int          gap        = 0;
	logic        clk_sys_i  = 1'b0;
	logic        rst_i      = 1'b1;
	logic        mod_bit_i  = 1'b1;
	logic        cs_n, sclk, din, dout, dout_oe, mod_sample, busy, res_new;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          n_new      = 0;
	logic [15:0] lfsr       = 16'h003A;
	logic [15:0] rd;
	logic [15:0] model_result;
	initial forever #5 clk_sys_i = ~clk_sys_i;
	acs_host_model acs_host_model_i (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk),
		.din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));
	acs_top #(.TIMEOUT_CYC(TO_CYC), .FIFO_DEPTH(8), .OSC_DIV(OSC_DIV)) acs_top_i (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout),
		.dout_oe_o(dout_oe), .mod_bit_i(mod_bit_i), .mod_sample_o(mod_sample),
		.conv_busy_o(busy), .result_new_o(res_new));
	always @(posedge clk_sys_i) if (res_new === 1'b1) n_new++;
	// ========
	// Model and compare helpers
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] conv_code(input longint cnt, input longint osr);
		longint v;
		v = ((cnt <<< 31) / osr) >>> 16;
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return v[15:0];
	endfunction
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ========
	// Watchdog: three conversions of 11600 cycles plus frames end near 37000
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		fail_count++;
		report_and_stop();
	end
	// ========
	// Main sequence
	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		lfsr = next_rand(lfsr);
		acs_host_model_i.xfer({1'b0, lfsr[5:0], 1'b1, 3'h7, lfsr[10:6]}, 16, 1'b0, rd);
		chk_word("idle read", 16'h0000, rd);
		repeat (50) @(negedge clk_sys_i);
		chk_bit("busy without start", 1'b0, busy);
		$display("test idle config done");
		// Misaligned leftovers would clear the start bit
		acs_host_model_i.xfer(16'h0000, 7, 1'b1, rd);
		repeat (TO_CYC + 20) @(negedge clk_sys_i);
		acs_host_model_i.xfer(16'h81E0, 16, 1'b1, rd);
		repeat (20) @(negedge clk_sys_i);
		chk_bit("busy after start", 1'b1, busy);
		repeat (1000) @(negedge clk_sys_i);
		acs_host_model_i.xfer(16'h01E0, 16, 1'b1, rd);
		chk_word("read during conversion", 16'h0000, rd);
		model_result = conv_code(OSR7, OSR7);
		for (int i = 0; i < 15000 && res_new !== 1'b1; i++) @(negedge clk_sys_i);
		repeat (500) @(negedge clk_sys_i);
		chk_bit("busy after single conversion", 1'b0, busy);
		chk_word("conversion count", 16'h0001, n_new[15:0]);
		acs_host_model_i.xfer(16'h01E0, 16, 1'b0, rd);
		chk_word("result read", model_result, rd);
		chk_bit("drive after deselect", 1'b0, dout_oe);
		$display("test single conversion done");
		// Continuous mode with an all-low bitstream
		mod_bit_i = 1'b0;
		lfsr = next_rand(lfsr);
		acs_host_model_i.xfer({1'b0, lfsr[5:0], 1'b0, 3'h7, lfsr[10:6]}, 16, 1'b0, rd);
		for (int i = 0; i < 15000 && res_new !== 1'b1; i++) @(negedge clk_sys_i);
		gap = 0;
		do begin
			@(negedge clk_sys_i);
			gap++;
		end while (res_new !== 1'b1 && gap < 15000);
		chk_word("conversion spacing", 16'(OSR7 * OSC_DIV * MOD_DIV), gap[15:0]);
		repeat (20) @(negedge clk_sys_i);
		chk_bit("busy in continuous", 1'b1, busy);
		chk_word("continuous count", 16'h0003, n_new[15:0]);
		model_result = conv_code(-OSR7, OSR7);
		acs_host_model_i.xfer(16'h00E0, 16, 1'b0, rd);
		chk_word("continuous read", model_result, rd);
		$display("test continuous conversion done");
		report_and_stop();
	end
endmodule
